// ---- bdr_host_model.sv ----
// Host side model: serial master framing and clocking 16-bit words
`timescale 1ns/1ps
`default_nettype none
module bdr_host_model (
    input  wire logic mclk_in,   // System clock, pacing only
    output logic      sck_out,   // Link clock, still outside frames
    output logic      cs_b_out,  // Frame select, active low
    output logic      sdi_out,   // Data towards the device
    input  wire logic sdo_in,    // Data from the device
    input  wire logic sdo_oe_in  // Device drives its data line
);
    localparam int HALF = 5; // Half link period in clocks, 80 ns period

    // Idle: frame closed, link clock low
    initial begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        sdi_out = 1'b0;
    end

    // Wait n falling system edges; all changes land there
    task automatic gap(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // MSB first framing; short counts allowed for refusals
    task automatic xfer(input logic [15:0] w, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        cs_b_out = 1'b0;
        gap(HALF);
        for (int i = 15; i > 15 - nbits; i--) begin
            sdi_out = w[i];
            gap(HALF);
            sck_out = 1'b1;
            // Undriven line must not pass for data
            rx = {rx[14:0], (sdo_oe_in === 1'b1) ? sdo_in : 1'bx};
            gap(HALF);
            sck_out = 1'b0;
        end
        gap(HALF);
        cs_b_out = 1'b1;
        // Released line shows the inverse so stale bits never match
        sdi_out = ~sdi_out;
        gap(2 * HALF);
    endtask
endmodule // bdr_host_model
`default_nettype wire

// ---- bdr_pkg.sv ----
// Constants and helpers for the bridge driver serial register bank
package bdr_pkg;
    // Serial word layout
    localparam int WORD_BITS  = 16;
    localparam int ADDR_MSB   = 15;
    localparam int ADDR_LSB   = 12;
    localparam int WR_BIT     = 11;
    localparam int PAY_MSB    = 10;
    localparam int PAY_LSB    = 1;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CNT_SAT    = 5'h11;

    // Register addresses
    localparam logic [3:0] ADDR_CFG_OLWR   = 4'h4;
    localparam logic [3:0] ADDR_CFG_SENSE  = 4'h5;
    localparam logic [3:0] ADDR_VCMD_SUPP  = 4'h6;
    localparam logic [3:0] ADDR_VCMD_BRDG  = 4'h7;
    localparam logic [3:0] ADDR_VRES_CONN  = 4'h8;
    localparam logic [3:0] ADDR_VRES_STATE = 4'h9;
    localparam logic [3:0] ADDR_MASK_GATE  = 4'ha;
    localparam logic [3:0] ADDR_MASK_SUPP  = 4'hb;

    // Payload reset values (payload bit n is word bit n+1)
    localparam logic [9:0] CFG_OLWR_RST  = 10'h060;
    localparam logic [9:0] CFG_SENSE_RST = 10'h0f5;
    localparam logic [9:0] ZERO_RST      = 10'h000;

    // Writable payload bits of each register
    localparam logic [9:0] CFG_OLWR_WMASK  = 10'h3ff;
    localparam logic [9:0] CFG_SENSE_WMASK = 10'h1f7;
    localparam logic [9:0] VCMD_SUPP_WMASK = 10'h3fc;
    localparam logic [9:0] VCMD_BRDG_WMASK = 10'h3ef;
    localparam logic [9:0] MASK_GATE_WMASK = 10'h0cf;
    localparam logic [9:0] MASK_SUPP_WMASK = 10'h3cf;

    // Field positions within the payload
    localparam int AOL_POS = 9;
    localparam int EWD_POS = 8;
    localparam int OLI_POS = 7;
    localparam int VRG_POS = 6;
    localparam int VPT_MSB = 5;
    localparam int DOO_POS = 8;
    localparam int SAO_MSB = 7;
    localparam int SAO_LSB = 4;
    localparam int SAG_MSB = 2;
    localparam int OP_POS  = 9;

    // Odd parity over a whole word is correct when the XOR is one
    function automatic logic word_odd(input logic [15:0] w);
        return ^w;
    endfunction

    // Sense amplifier offset in millivolts per code
    function automatic logic [11:0] offset_mv(input logic [3:0] c);
        logic [11:0] r;
        r = 12'h000;
        if (c < 4'h2) begin
            r = 12'h000;
        end else if (c < 4'h4) begin
            r = 12'h064;
        end else if (c < 4'h8) begin
            r = 12'(({8'h00, c} - 12'h002) * 12'h064);
        end else if (c == 4'h8) begin
            r = 12'h2ee;
        end else begin
            r = 12'(({8'h00, c} - 12'h005) * 12'h0fa);
        end
        return r;
    endfunction

    // Sense amplifier gain per code
    function automatic logic [5:0] gain_of(input logic [2:0] c);
        if (c == 3'h7) begin
            return 6'h32;
        end
        return 6'(6'h0a + {3'h0, c} * 6'h05);
    endfunction
endpackage

// ---- bdr_serial_regs.sv ----
// Serial register bank: later config, verification and fault mask words
// Notes on behaviour
// - Bit 0 makes word parity odd
// - Serial error flag on bad previous transfer
// - On-state open-load enable: 0 off, 1 on
// - Watchdog enable: 0 inactive, 1 active
// - Test current select: 0 100uA, 1 400uA
// - Regulator select: 0 8V, 1 13V, default 1
// - Phase threshold code n gives n/64
// - Offset code maps to fixed millivolt table
// - Gain code 0-6 gives 10-40, 7 gives 50
// - Off-state open-load disable: 1 turns detection off
// - Monitor verification bits: 1 active
// - Phase select routes off-state check A/B
// - Writing 1 starts bridge verification check
// - Connect result word is read-only status
// - State result word is read-only status
// - Gate mask bits: 1 disables fault detection
// - Supply/drain mask bits: 1 disables detection
// - Reset loads every payload default
`timescale 1ns/1ps
`default_nettype none
module bdr_serial_regs (
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        sck_in,
    input  wire logic        cs_b_in,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    output logic             serial_error_flag_out,
    output logic             onstate_openload_enable_out,
    output logic             enable_input_watchdog_on_out,
    output logic             offstate_test_current_select_out,
    output logic             regulator_level_select_out,
    output logic [5:0]       phase_threshold_code_out,
    output logic             offstate_openload_disable_out,
    output logic [3:0]       sense_offset_code_out,
    output logic [11:0]      sense_offset_mv_out,
    output logic [2:0]       sense_gain_code_out,
    output logic [5:0]       sense_gain_out,
    output logic [7:0]       verify_monitor_out,
    output logic             offstate_phase_select_out,
    output logic [7:0]       verify_bridge_out,
    output logic [7:0]       verify_bridge_start_out,
    input  wire logic [4:0]  verify_result_connect_in,
    input  wire logic [2:0]  verify_result_state_in,
    output logic [5:0]       fault_mask_gate_out,
    output logic [7:0]       fault_mask_supply_drain_out
);
    // Whole module state in one record
    typedef struct packed {
        logic [1:0]      sck_sync;   // Link clock synchroniser
        logic [1:0]      cs_sync;    // Select synchroniser
        logic [1:0]      sdi_sync;   // Data synchroniser
        logic [1:0][4:0] conn_sync;  // Connect result synchroniser
        logic [1:0][2:0] state_sync; // State result synchroniser
        logic            sck_last;   // Previous synced clock level
        logic            cs_last;    // Previous synced select level
        logic [4:0]      bit_cnt;    // Bits taken this frame
        logic [15:0]     rx_word;    // Incoming shift register
        logic [15:0]     tx_word;    // Outgoing shift register
        logic [3:0]      rd_addr;    // Address answered next frame
        logic            ser_err;    // Last frame was bad
        logic            sdo_oe;     // Driving the output pin
        logic [9:0]      cfg_olwr;
        logic [9:0]      cfg_sense;
        logic [9:0]      vcmd_supp;
        logic [9:0]      vcmd_brdg;
        logic [9:0]      mask_gate;
        logic [9:0]      mask_supp;
        logic [7:0]      vstart;     // One-cycle check start
        logic [11:0]     off_mv;     // Decoded offset
        logic [5:0]      gain;       // Decoded gain
    } bdr_state_s;

    // Reset image; select idles high so no false frame start
    // Reset defaults
    localparam bdr_state_s RST_STATE = '{
        cs_sync:   2'h3,
        cs_last:   1'b1,
        cfg_olwr:  bdr_pkg::CFG_OLWR_RST,
        cfg_sense: bdr_pkg::CFG_SENSE_RST,
        off_mv:    bdr_pkg::offset_mv(bdr_pkg::CFG_SENSE_RST[7:4]),
        gain:      bdr_pkg::gain_of(bdr_pkg::CFG_SENSE_RST[2:0]),
        default:   '0
    };

    bdr_state_s q_ff;     // Registered state
    bdr_state_s nxt_q;    // Next state
    logic       sck_rise; // Synced link clock rising
    logic       sck_fall; // Synced link clock falling
    logic       cs_start; // Frame opens
    logic       cs_end;   // Frame closes
    logic       frm_good; // Closing frame is clean
    logic [3:0] w_addr;   // Address field of received word
    logic [9:0] w_pay;    // Payload field of received word
    logic [9:0] rd_pay;   // Payload of register to answer

    // Edges seen only from second synchroniser stage
    assign sck_rise = q_ff.sck_sync[1] & ~q_ff.sck_last;
    assign sck_fall = ~q_ff.sck_sync[1] & q_ff.sck_last;
    assign cs_start = ~q_ff.cs_sync[1] & q_ff.cs_last;
    assign cs_end   = q_ff.cs_sync[1] & ~q_ff.cs_last;
    assign w_addr = q_ff.rx_word[bdr_pkg::ADDR_MSB:bdr_pkg::ADDR_LSB];
    assign w_pay  = q_ff.rx_word[bdr_pkg::PAY_MSB:bdr_pkg::PAY_LSB];
    // Exactly 16 bits and odd parity
    assign frm_good = cs_end && (q_ff.bit_cnt == bdr_pkg::FRAME_BITS)
                      && bdr_pkg::word_odd(q_ff.rx_word);

    // Readback mux; unlisted addresses answer zero payload
    always_comb begin
        case (q_ff.rd_addr)
            bdr_pkg::ADDR_CFG_OLWR:  rd_pay = q_ff.cfg_olwr;
            bdr_pkg::ADDR_CFG_SENSE: rd_pay = q_ff.cfg_sense;
            bdr_pkg::ADDR_VCMD_SUPP: rd_pay = q_ff.vcmd_supp;
            bdr_pkg::ADDR_VCMD_BRDG: rd_pay = q_ff.vcmd_brdg;
            // Connect results from the analog side
            bdr_pkg::ADDR_VRES_CONN: rd_pay = {4'h0,
                q_ff.conn_sync[1][4:2], 1'b0, q_ff.conn_sync[1][1:0]};
            // State results from the analog side
            bdr_pkg::ADDR_VRES_STATE: rd_pay = {5'h00,
                q_ff.state_sync[1][2:1], 2'h0, q_ff.state_sync[1][0]};
            bdr_pkg::ADDR_MASK_GATE: rd_pay = q_ff.mask_gate;
            bdr_pkg::ADDR_MASK_SUPP: rd_pay = q_ff.mask_supp;
            default:                 rd_pay = 10'h000;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        nxt_q = q_ff;
        // Two-stage synchronisers for every outside input except the reset
        nxt_q.sck_sync   = {q_ff.sck_sync[0], sck_in};
        nxt_q.cs_sync    = {q_ff.cs_sync[0], cs_b_in};
        nxt_q.sdi_sync   = {q_ff.sdi_sync[0], sdi_in};
        nxt_q.conn_sync  = {q_ff.conn_sync[0], verify_result_connect_in};
        nxt_q.state_sync = {q_ff.state_sync[0], verify_result_state_in};
        nxt_q.sck_last   = q_ff.sck_sync[1];
        nxt_q.cs_last    = q_ff.cs_sync[1];
        nxt_q.vstart     = 8'h00;
        if (cs_start) begin
            // New frame: clear counter, load answer word
            nxt_q.bit_cnt = 5'h00;
            nxt_q.sdo_oe  = 1'b1;
            // Outgoing parity makes the word odd
            nxt_q.tx_word = {q_ff.rd_addr, 1'b0, rd_pay,
                ~(^{q_ff.rd_addr, rd_pay})};
        end else if (!q_ff.cs_sync[1]) begin
            if (sck_rise) begin
                // Take one bit, MSB first
                nxt_q.rx_word = {q_ff.rx_word[14:0], q_ff.sdi_sync[1]};
                // Saturate so long frames stay detectable
                if (q_ff.bit_cnt != bdr_pkg::CNT_SAT) begin
                    nxt_q.bit_cnt = q_ff.bit_cnt + 5'h01;
                end
            end else if (sck_fall) begin
                nxt_q.tx_word = {q_ff.tx_word[14:0], 1'b0};
            end
        end
        if (cs_end) begin
            nxt_q.sdo_oe = 1'b0;
            // Flag reflects the frame just closed
            nxt_q.ser_err = ~frm_good;
        end
        if (frm_good) begin
            nxt_q.rd_addr = w_addr;
            // Only flagged writes to writable words land
            if (q_ff.rx_word[bdr_pkg::WR_BIT]) begin
                case (w_addr)
                    bdr_pkg::ADDR_CFG_OLWR:
                        nxt_q.cfg_olwr = w_pay & bdr_pkg::CFG_OLWR_WMASK;
                    bdr_pkg::ADDR_CFG_SENSE:
                        nxt_q.cfg_sense = w_pay & bdr_pkg::CFG_SENSE_WMASK;
                    bdr_pkg::ADDR_VCMD_SUPP:
                        nxt_q.vcmd_supp = w_pay & bdr_pkg::VCMD_SUPP_WMASK;
                    bdr_pkg::ADDR_VCMD_BRDG: begin
                        nxt_q.vcmd_brdg = w_pay & bdr_pkg::VCMD_BRDG_WMASK;
                        // Start each check written as one
                        nxt_q.vstart = {w_pay[8:5], w_pay[3:0]};
                    end
                    bdr_pkg::ADDR_MASK_GATE:
                        nxt_q.mask_gate = w_pay & bdr_pkg::MASK_GATE_WMASK;
                    bdr_pkg::ADDR_MASK_SUPP:
                        nxt_q.mask_supp = w_pay & bdr_pkg::MASK_SUPP_WMASK;
                    // Result words and other addresses ignore writes
                    default: nxt_q.rd_addr = w_addr;
                endcase
            end
        end
        // Offset table, held in a flop for a clean output
        nxt_q.off_mv = bdr_pkg::offset_mv(
            nxt_q.cfg_sense[bdr_pkg::SAO_MSB:bdr_pkg::SAO_LSB]);
        nxt_q.gain = bdr_pkg::gain_of(nxt_q.cfg_sense[bdr_pkg::SAG_MSB:0]);
    end

    // State register with asynchronous reset
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q_ff <= RST_STATE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Pin and field outputs straight from state
    assign sdo_out                = q_ff.tx_word[15];
    assign sdo_oe_out             = q_ff.sdo_oe;
    assign serial_error_flag_out  = q_ff.ser_err;
    assign onstate_openload_enable_out = q_ff.cfg_olwr[bdr_pkg::AOL_POS];
    assign enable_input_watchdog_on_out = q_ff.cfg_olwr[bdr_pkg::EWD_POS];
    assign offstate_test_current_select_out =
        q_ff.cfg_olwr[bdr_pkg::OLI_POS];
    assign regulator_level_select_out = q_ff.cfg_olwr[bdr_pkg::VRG_POS];
    // Threshold code passed to the comparator DAC
    assign phase_threshold_code_out = q_ff.cfg_olwr[bdr_pkg::VPT_MSB:0];
    assign offstate_openload_disable_out = q_ff.cfg_sense[bdr_pkg::DOO_POS];
    assign sense_offset_code_out =
        q_ff.cfg_sense[bdr_pkg::SAO_MSB:bdr_pkg::SAO_LSB];
    assign sense_offset_mv_out   = q_ff.off_mv;
    assign sense_gain_code_out   = q_ff.cfg_sense[bdr_pkg::SAG_MSB:0];
    assign sense_gain_out        = q_ff.gain;
    assign verify_monitor_out    = q_ff.vcmd_supp[9:2];
    assign offstate_phase_select_out = q_ff.vcmd_brdg[bdr_pkg::OP_POS];
    assign verify_bridge_out = {q_ff.vcmd_brdg[8:5], q_ff.vcmd_brdg[3:0]};
    assign verify_bridge_start_out = q_ff.vstart;
    assign fault_mask_gate_out = {q_ff.mask_gate[7:6], q_ff.mask_gate[3:0]};
    assign fault_mask_supply_drain_out =
        {q_ff.mask_supp[9:6], q_ff.mask_supp[3:0]};

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // Clean write of config word lands next cycle
    chk_cfg_write: assert property (
        frm_good && q_ff.rx_word[11] && w_addr == 4'h4
        |=> q_ff.cfg_olwr == $past(w_pay))
        else $error("config write lost");
    // Even parity frame is refused and flagged
    chk_parity_refuse: assert property (
        cs_end && !bdr_pkg::word_odd(q_ff.rx_word)
        |=> serial_error_flag_out && $stable(q_ff.cfg_olwr))
        else $error("even parity accepted");
    // Short or long frame raises the error flag
    chk_len_error: assert property (
        cs_end && q_ff.bit_cnt != 5'h10 |=> serial_error_flag_out)
        else $error("bad length not flagged");
    // Start pulse only after a bridge command write, one cycle
    chk_start_pulse: assert property (
        verify_bridge_start_out != 8'h00
        |-> $past(frm_good && w_addr == 4'h7)
        ##1 verify_bridge_start_out == 8'h00)
        else $error("stray check start");
    // Read-only frame keeps the sense config, supply mask and bridge command words
    chk_read_stable: assert property (
        frm_good && !q_ff.rx_word[11]
        |=> $stable(q_ff.cfg_sense) && $stable(q_ff.mask_supp)
            && $stable(q_ff.vcmd_brdg))
        else $error("read changed a register");
    // Writes to result words leave others alone
    chk_result_nowrite: assert property (
        frm_good && (w_addr == 4'h8 || w_addr == 4'h9)
        |=> $stable(q_ff.mask_gate) && verify_bridge_start_out == 8'h00)
        else $error("result write had effect");
    // Gain code seven gives fifty, zero gives ten
    chk_gain_map: assert property (
        (sense_gain_code_out == 3'h7 |-> sense_gain_out == 6'h32) and
        (sense_gain_code_out == 3'h0 |-> sense_gain_out == 6'h0a))
        else $error("gain decode wrong");
    // Offset code eight gives 750 mV, fifteen gives 2500 mV
    chk_offset_map: assert property (
        (sense_offset_code_out == 4'h8 |-> sense_offset_mv_out == 12'h2ee)
        and (sense_offset_code_out == 4'hf
             |-> sense_offset_mv_out == 12'h9c4))
        else $error("offset decode wrong");
    // Defaults hold while reset is applied
    chk_reset_values: assert property (@(posedge mclk_in)
        disable iff (1'b0) !rst_b_in |-> regulator_level_select_out
        && phase_threshold_code_out == 6'h20
        && sense_offset_code_out == 4'hf && sense_gain_code_out == 3'h5
        && fault_mask_gate_out == 6'h00 && verify_monitor_out == 8'h00)
        else $error("reset defaults wrong");

    cov_good_write: cover property (frm_good && q_ff.rx_word[11]);
    cov_bad_frame: cover property (cs_end && !frm_good);
    cov_check_start: cover property (verify_bridge_start_out != 8'h00);
    cov_result_read: cover property (cs_start && q_ff.rd_addr == 4'h8);
endmodule // bdr_serial_regs
`default_nettype wire

// ---- test_bdr_serial_regs.sv ----
// Self-checking bench for the serial register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
    end end
module test_bdr_serial_regs;
    localparam int LIMIT = 20000; // Ceiling in clocks, run needs ~8300
    logic        mclk = 1'b0;     // System clock
    logic        rst_b = 1'b1;    // Reset, active low, pulled at 1 ns
    logic [4:0]  conn = 5'h00;    // Connect results from the bridge
    logic [2:0]  st = 3'h0;       // State results from the bridge
    wire         sck, cs_b, sdi;  // Link from the host model
    logic        sdo, sdo_oe, err, onstate_openload_enable, enable_input_watchdog_on, offstate_test_current_select, regulator_level_select, offstate_openload_disable, op;
    logic [5:0]  phase_threshold_code, gain, mgate;
    logic [3:0]  sense_offset_code;
    logic [11:0] mv;
    logic [2:0]  sense_gain_code;
    logic [7:0]  mon, brg, go, msup;
    logic [7:0]  seen = 8'h00;    // Start pulses caught since last clear
    logic [15:0] rx;              // Word returned by the last frame
    int          num_errors = 0, samples_checked = 0, cycles = 0;

    bdr_host_model host (.mclk_in(mclk), .sck_out(sck), .cs_b_out(cs_b),
        .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
    bdr_serial_regs uut (.mclk_in(mclk), .rst_b_in(rst_b), .sck_in(sck),
        .cs_b_in(cs_b), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
        .serial_error_flag_out(err), .onstate_openload_enable_out(onstate_openload_enable),
        .enable_input_watchdog_on_out(enable_input_watchdog_on),
        .offstate_test_current_select_out(offstate_test_current_select),
        .regulator_level_select_out(regulator_level_select), .phase_threshold_code_out(phase_threshold_code),
        .offstate_openload_disable_out(offstate_openload_disable), .sense_offset_code_out(sense_offset_code),
        .sense_offset_mv_out(mv), .sense_gain_code_out(sense_gain_code),
        .sense_gain_out(gain), .verify_monitor_out(mon),
        .offstate_phase_select_out(op), .verify_bridge_out(brg),
        .verify_bridge_start_out(go), .verify_result_connect_in(conn),
        .verify_result_state_in(st), .fault_mask_gate_out(mgate),
        .fault_mask_supply_drain_out(msup));

    // Clock, timeout and start pulse catcher
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        seen <= seen | go;
        if (cycles == LIMIT) begin
            num_errors++;
            end_sim();
        end
    end

    // Word builder; parity bit makes the ones count odd
    function automatic logic [15:0] mk(input logic [3:0] a,
                                       input logic wr, input logic [9:0] p);
        return {a, wr, p, ~^{a, wr, p}};
    endfunction

    task automatic xf(input logic [15:0] w, input int n);
        host.xfer(w, n, rx);
    endtask

    // Readback shows the register named by the previous clean frame
    task automatic rdchk(input logic [3:0] a, input logic [9:0] p);
        xf(mk(a, 1'b0, 10'h000), 16);
        xf(mk(a, 1'b0, 10'h000), 16);
        `CHK(rx, mk(a, 1'b0, p))
    endtask

    task automatic t_reset();
        `CHK({onstate_openload_enable, enable_input_watchdog_on, offstate_test_current_select, regulator_level_select, phase_threshold_code}, 10'h060)
        `CHK({offstate_openload_disable, sense_offset_code, sense_gain_code}, 8'h7d)
        `CHK({mv, gain}, {12'h9c4, 6'h23})
        `CHK({mon, op, brg, mgate, msup}, 31'h0)
        `CHK({sdo_oe, err}, 2'b00)
        rdchk(4'h4, 10'h060);
        rdchk(4'h5, 10'h0f5);
        $display("test reset done");
    endtask

    task automatic t_cfg4();
        logic [9:0] p [3] = '{10'h2d5, 10'h13f, 10'h000};
        foreach (p[i]) begin
            xf(mk(4'h4, 1'b1, p[i]), 16);
            `CHK({onstate_openload_enable, enable_input_watchdog_on, offstate_test_current_select, regulator_level_select, phase_threshold_code}, p[i])
        end
        // Write flag clear must leave the register alone
        xf(mk(4'h4, 1'b0, 10'h3ff), 16);
        `CHK({onstate_openload_enable, regulator_level_select, phase_threshold_code}, 8'h00)
        `CHK(rx, mk(4'h4, 1'b0, 10'h000))
        $display("test config4 done");
    endtask

    task automatic t_cfg5();
        logic [11:0] tbl [16] = '{12'h000, 12'h000, 12'h064, 12'h064,
            12'h0c8, 12'h12c, 12'h190, 12'h1f4, 12'h2ee, 12'h3e8,
            12'h4e2, 12'h5dc, 12'h6d6, 12'h7d0, 12'h8ca, 12'h9c4};
        logic [3:0] c;
        logic [5:0] g;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            g = (c[2:0] == 3'h7) ? 6'h32 : 6'(10 + 5 * int'(c[2:0]));
            xf(mk(4'h5, 1'b1, {1'b0, c[0], c, 1'b0, c[2:0]}), 16);
            `CHK({offstate_openload_disable, sense_offset_code, sense_gain_code}, {c[0], c, c[2:0]})
            `CHK(mv, tbl[i])
            `CHK(gain, g)
        end
        xf(mk(4'h5, 1'b1, 10'h3ff), 16);
        rdchk(4'h5, 10'h1f7);
        $display("test config5 done");
    endtask

    task automatic t_verify();
        xf(mk(4'h6, 1'b1, 10'h3fc), 16);
        `CHK(mon, 8'hff)
        xf(mk(4'h6, 1'b1, 10'h154), 16);
        `CHK(mon, 8'h55)
        seen = 8'h00;
        xf(mk(4'h7, 1'b1, 10'h3ef), 16);
        `CHK({op, brg, seen}, 17'h1ffff)
        seen = 8'h00;
        xf(mk(4'h7, 1'b1, 10'h021), 16);
        `CHK({op, brg, seen}, {1'b0, 8'h11, 8'h11})
        // Read frame and parity fault must start nothing
        seen = 8'h00;
        xf(mk(4'h7, 1'b0, 10'h3ef), 16);
        xf(mk(4'h7, 1'b1, 10'h3ef) ^ 16'h0001, 16);
        `CHK({op, brg, seen}, {1'b0, 8'h11, 8'h00})
        $display("test verify done");
    endtask

    task automatic t_errors();
        xf(mk(4'hb, 1'b1, 10'h3ff) ^ 16'h0001, 16);
        `CHK({err, msup}, 9'h100)
        xf(mk(4'h4, 1'b0, 10'h000), 16);
        `CHK(err, 1'b0)
        // Frame one bit short is refused as well
        xf(mk(4'hb, 1'b1, 10'h3ff), 15);
        `CHK({err, msup}, 9'h100)
        xf(mk(4'h4, 1'b0, 10'h000), 16);
        `CHK({err, sdo_oe}, 2'b00)
        $display("test errors done");
    endtask

    task automatic t_results();
        conn = 5'h15;
        st = 3'h5;
        xf(mk(4'h8, 1'b1, 10'h3ff), 16);
        xf(mk(4'h9, 1'b0, 10'h000), 16);
        `CHK(rx, mk(4'h8, 1'b0, 10'h029))
        xf(mk(4'h9, 1'b0, 10'h000), 16);
        `CHK(rx, mk(4'h9, 1'b0, 10'h011))
        // Unlisted address takes no write and reads back zero
        xf(mk(4'hc, 1'b1, 10'h3ff), 16);
        xf(mk(4'h4, 1'b0, 10'h000), 16);
        `CHK(rx, mk(4'hc, 1'b0, 10'h000))
        `CHK({err, mgate, msup, go}, 23'h0)
        $display("test results done");
    endtask

    task automatic t_masks();
        xf(mk(4'ha, 1'b1, 10'h3ff), 16);
        `CHK(mgate, 6'h3f)
        xf(mk(4'hb, 1'b1, 10'h2c5), 16);
        `CHK(msup, 8'hb5)
        rdchk(4'ha, 10'h0cf);
        $display("test masks done");
    endtask

    // Single exit: counts, verdict, finish
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reset for 20 clocks, idle link settles, then the tests
    // Reset falls before the first clock so no edge sees unknown state
    initial begin
        #1 rst_b = 1'b0;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_cfg4();
        t_cfg5();
        t_verify();
        t_errors();
        t_results();
        t_masks();
        end_sim();
    end
endmodule // test_bdr_serial_regs
`default_nettype wire
